// ### dv/chcp_dev_model.sv
// device model: spi slave with flags, replies, sleep
// assumes sck idles low between frames
`timescale 1ns/1ps
module chcp_dev_model (
  input  wire sck,
  input  wire ss_n,
  input  wire mosi,
  output wire miso,
  input  wire irq_in_n,
  output wire irq_out_n
);
  reg [7:0] sh, ctl, out, c, l, p;
  reg [7:0] rsp [0:1];
  reg       drv = 1'h0, rdy = 1'h0, slp = 1'h0;
  integer   bi = 0, nb = 0, rn = 0;
  // released line shows the inverse bit
  assign miso = ss_n ? ~drv : drv;
  assign irq_out_n = !rdy;
  // frame start
  always @(negedge ss_n) begin
    bi = 0;
    nb = 0;
  end
  // shift in msb first, load next byte out
  always @(posedge sck) if (!ss_n) begin
    sh = {sh[6:0], mosi};
    bi = bi + 1;
    if (bi == 8) begin
      bi = 0;
      if (nb == 0) ctl = sh;
      if (nb == 1) c = sh;
      if (nb == 2) l = sh;
      if (nb == 3) p = sh;
      nb = nb + 1;
      out = ctl[7:6] == 2'h3 ? {4'hA, rdy, !rdy, 2'h1} : rsp[~nb[0]];
    end
  end
  // next bit on falling sck
  always @(negedge sck) if (!ss_n) drv = out[7 - bi];
  // operation acts once select rises
  always @(posedge ss_n) begin
    if (ctl[7:6] == 2'h1) slp = 1'h1;
    if (ctl[7:6] == 2'h1 || (ctl[7:6] == 2'h2 && nb > rn)) rdy = 1'h0;
    if (ctl[7:6] == 2'h0 && nb > 1 && !slp) begin
      rn = c == 8'h55 ? 1 : 2;
      rsp[0] = c == 8'h55 ? 8'h55 : c != 8'h02 ? 8'h00 : l != 8'h02 ? 8'h82 : p > 8'h04 ? 8'h83 : 8'h00;
      rsp[1] = 8'h00;
      rdy <= #3000 1'h1;
    end
  end
  // wake pulse ends sleep
  always @(negedge irq_in_n) slp = 1'h0;
endmodule // chcp_dev_model

// ### dv/chcp_host_checker.sv
// checker: pin timing of the spi host port
// assumes every count parameter set to 4
`timescale 1ns/1ps
module chcp_host_checker (
  input wire ref_clk,
  input wire rst_n,
  input wire cmd_valid,
  input wire cmd_ready,
  input wire busy,
  input wire done,
  input wire spi_sck,
  input wire spi_ss_n,
  input wire spi_mosi,
  input wire irq_in_n,
  input wire link_select_0,
  input wire link_select_1
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // framing, bit timing, wake pulse, link strap and command handshake
  sck_idle_a: assert property (spi_ss_n |-> !spi_sck) else $error("sck idle");
  mosi_hold_a: assert property ($rose(spi_sck) |-> $stable(spi_mosi)) else $error("mosi moved");
  sck_high_a: assert property ($rose(spi_sck) |-> spi_sck[*4] ##1 !spi_sck) else $error("sck high");
  frame_gap_a: assert property ($rose(spi_ss_n) |-> spi_ss_n[*4]) else $error("select gap");
  wake_len_a: assert property ($fell(irq_in_n) |-> (!irq_in_n)[*4] ##1 irq_in_n) else $error("wake len");
  link_sel_a: assert property (link_select_0 && !link_select_1) else $error("link strap");
  take_sel_a: assert property (cmd_valid && cmd_ready |-> ##[1:2] !spi_ss_n) else $error("no select");
  one_op_a: assert property (!spi_ss_n |-> busy && !cmd_ready) else $error("ready in frame");
  done_one_a: assert property (done |=> !done) else $error("done long");
endmodule // chcp_host_checker
bind chcp_host chcp_host_checker chk (.ref_clk(ref_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .busy(busy), .done(done), .spi_sck(spi_sck), .spi_ss_n(spi_ss_n),
  .spi_mosi(spi_mosi), .irq_in_n(irq_in_n), .link_select_0(link_select_0), .link_select_1(link_select_1));

// ### dv/tb.sv
// bench: spi host port against the device model
// assumes a short wake pulse count
`timescale 1ns/1ps
`include "chcp_defines.vh"
module tb;
  reg        ref_clk = 1'h0, rst_n = 1'h0, cmd_valid = 1'h0, cmd_wake = 1'h0, irq_mode = 1'h0;
  reg        tx_valid = 1'h0, tx_last = 1'h0, took = 1'h0;
  reg  [1:0] cmd_op = 2'h0;
  reg  [7:0] tx_data = 8'h00;
  wire       cmd_ready, tx_ready, rx_valid, rx_last, done, busy, link_select_0, link_select_1;
  wire       spi_sck, spi_ss_n, spi_mosi, spi_miso, irq_in_n, irq_out_n;
  wire [7:0] rx_data, poll_flags;
  integer    miscompares = 0, n_compared = 0, seed = 64373, j, k;
  reg  [7:0] txq [$];
  reg  [8:0] eq [$];
  reg  [1:0] fq [$];
  reg  [1:0] taken_op_q = 2'h0;
  chcp_host #(.WAKE_CYC(4)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_wake(cmd_wake), .irq_mode(irq_mode), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data), .tx_last(tx_last), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
    .poll_flags(poll_flags), .done(done), .busy(busy), .link_select_0(link_select_0),
    .link_select_1(link_select_1), .spi_sck(spi_sck), .spi_ss_n(spi_ss_n), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .irq_in_n(irq_in_n), .irq_out_n(irq_out_n));
  chcp_dev_model dev (.sck(spi_sck), .ss_n(spi_ss_n), .mosi(spi_mosi), .miso(spi_miso),
    .irq_in_n(irq_in_n), .irq_out_n(irq_out_n));
  initial forever #25 ref_clk = ~ref_clk;
  ////////////////////////////////////////
  task cmp(input [8:0] e, input [8:0] g);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("ERROR %0t got %h want %h", $time, g, e);
      end
    end
  endtask
  task cmp_flags(input [1:0] e, input [1:0] g);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("ERROR %0t flags %b want %b", $time, g, e);
      end
    end
  endtask
  task conclude;
    begin
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  task go(input [1:0] op, input w);
    begin
      cmd_op = op;
      cmd_wake = w;
      cmd_valid = !w;
      while (cmd_ready !== 1'h1) @(negedge ref_clk);
      @(negedge ref_clk);
      cmd_valid = 1'h0;
      cmd_wake = 1'h0;
      while (done !== 1'h1) @(negedge ref_clk);
    end
  endtask
  task xact(input [8:0] e, input two);
    begin
      go(`CHCP_OP_SEND, 1'h0);
      repeat (2) begin
        if (!irq_mode) fq.push_back(2'h2);
        go(`CHCP_OP_POLL, 1'h0);
      end
      eq.push_back(e);
      if (two) eq.push_back(9'h100);
      go(`CHCP_OP_READ, 1'h0);
    end
  endtask
  ////////////////////////////////////////
  // operation the host took, for the poll check
  always @(posedge ref_clk) if (cmd_valid && cmd_ready === 1'h1) taken_op_q <= cmd_op;
  // byte feeder and scoreboard
  always @(negedge ref_clk) begin
    if (took) txq.delete(0);
    took = tx_ready === 1'h1 && tx_valid;
    tx_valid = txq.size() > 0;
    tx_data = txq.size() > 0 ? txq[0] : 8'h00;
    tx_last = txq.size() == 1;
    if (rx_valid === 1'h1) cmp(eq.pop_front(), {rx_last, rx_data});
    if (done === 1'h1 && taken_op_q == `CHCP_OP_POLL && fq.size() > 0)
      cmp_flags(fq.pop_front(), poll_flags[3:2]);
  end
  // watchdog
  initial begin
    #2000000;
    miscompares = miscompares + 1;
    $display("ERROR %0t timeout", $time);
    conclude;
  end
  // main sequence
  initial begin
    repeat (5) @(negedge ref_clk);
    rst_n = 1'h1;
    repeat (3) @(negedge ref_clk);
    go(2'h0, 1'h1);
    txq = '{8'h55};
    xact(9'h155, 1'h0);
    for (j = 0; j < 7; j = j + 1) begin
      irq_mode = j[0];
      k = $random(seed);
      txq = '{8'h02, 8'h02, j[7:0], k[7:0]};
      if (j == 6) txq = '{8'h02, 8'h00};
      xact(j == 6 ? 9'h082 : j == 5 ? 9'h083 : 9'h000, 1'h1);
    end
    go(`CHCP_OP_RESET, 1'h0);
    txq = '{8'h55};
    xact(9'h155, 1'h0);
    conclude;
  end
endmodule // tb

// ### hdl/chcp_defines.vh
// constants for the contactless reader host command port
// assumes a 20 MHz reference clock feeding the host controller
`ifndef CHCP_DEFINES_VH
`define CHCP_DEFINES_VH

// spi control byte operation codes
`define CHCP_OP_SEND      2'h0
`define CHCP_OP_RESET     2'h1
`define CHCP_OP_READ      2'h2
`define CHCP_OP_POLL      2'h3

// flag byte fields
`define CHCP_FLAG_READ_BIT  3
`define CHCP_FLAG_SEND_BIT  2

// command and result codes
`define CHCP_CMD_IDENTIFY   8'h01
`define CHCP_CMD_PROTOCOL   8'h02
`define CHCP_CMD_EXCHANGE   8'h04
`define CHCP_CMD_IDLE       8'h07
`define CHCP_CMD_REG_READ   8'h08
`define CHCP_CMD_REG_WRITE  8'h09
`define CHCP_CMD_SPEED      8'h0A
`define CHCP_CMD_LOOPBACK   8'h55
`define CHCP_RES_OK         8'h00
`define CHCP_RES_BAD_LEN    8'h82
`define CHCP_RES_BAD_PROTO  8'h83
`define CHCP_DUMMY_BYTE     8'h00

// link select strap levels: spi
`define CHCP_LINK_SEL0      1'b1
`define CHCP_LINK_SEL1      1'b0

// timing
`define CHCP_CLK_PERIOD_NS  50
`define CHCP_WAKE_PULSE_NS  10000
`define CHCP_SCK_HALF_CYC   4
`define CHCP_SS_GAP_CYC     4

`endif

// ### hdl/chcp_host.v
// host-side spi controller for a contactless reader transceiver
// assumes the device strapped to the spi link and wired pin to pin
//
// Behaviour
// - serial link characters go lsb first with two-unit stop bits
// - host regains serial framing by repeating loopback, 255 at most
// - every spi transaction opens with control code 00 send 11 poll 10 read 01 reset
// - spi data sampled on rising sck edge, msb first both ways
// - host raises select between transactions and reads only after ready flag; here a read op starts on command without checking the flag
// - polling repeats flag bytes within one transaction as often as needed
// - frames carry code, length and 0 to 255 data bytes
// - loopback is the lone byte 55 answered by 55
// - identify replies 00, length, ascii id, rom checksum after about 6 ms
// - wait-time bytes need exponent at most 0E and multiplier 01 to FE
`timescale 1ns/1ps
`include "chcp_defines.vh"

module chcp_host #(
  parameter WAKE_CYC = (`CHCP_WAKE_PULSE_NS + `CHCP_CLK_PERIOD_NS - 1) / `CHCP_CLK_PERIOD_NS,
  parameter HALF_CYC = `CHCP_SCK_HALF_CYC,
  parameter GAP_CYC  = `CHCP_SS_GAP_CYC
) (
  input  wire       ref_clk,
  input  wire       rst_n,
  input  wire       cmd_valid,
  output wire       cmd_ready,
  input  wire [1:0] cmd_op,
  input  wire       cmd_wake,
  input  wire       irq_mode,
  input  wire       tx_valid,
  output wire       tx_ready,
  input  wire [7:0] tx_data,
  input  wire       tx_last,
  output reg        rx_valid,
  output reg  [7:0] rx_data,
  output reg        rx_last,
  output reg  [7:0] poll_flags,
  output reg        done,
  output wire       busy,
  output reg        link_select_0,
  output reg        link_select_1,
  output reg        spi_sck,
  output reg        spi_ss_n,
  output reg        spi_mosi,
  input  wire       spi_miso,
  output reg        irq_in_n,
  input  wire       irq_out_n
);

  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_WAKE = 3'h1;
  localparam [2:0] S_BIT  = 3'h2;
  localparam [2:0] S_NEXT = 3'h3;
  localparam [2:0] S_GAP  = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers
  reg  [1:0] rst_sync_q;
  wire       rst_int_n = rst_sync_q[1];
  reg  [1:0] miso_sync_q;
  reg  [1:0] irq_sync_q;

  // reset released through two flops
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  // two-flop synchronisers on device outputs
  always @(posedge ref_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      miso_sync_q <= 2'h0;
      irq_sync_q  <= 2'h3;
    end else begin
      miso_sync_q <= {miso_sync_q[0], spi_miso};
      irq_sync_q  <= {irq_sync_q[0], irq_out_n};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transaction engine
  reg  [2:0]  state_q;
  reg  [1:0]  op_q;
  reg  [15:0] cnt_q;
  reg  [2:0]  bit_q;
  reg  [7:0]  sh_q;
  reg         samp_q;
  reg         first_q;
  reg         last_sent_q;
  reg  [8:0]  idx_q;
  reg  [7:0]  len_q;

  wire irq_ready = irq_mode && !irq_sync_q[1];
  wire need_tx   = (state_q == S_NEXT) && (op_q == `CHCP_OP_SEND) && (first_q || !last_sent_q);
  wire read_end  = (idx_q == 9'h000 && sh_q == `CHCP_CMD_LOOPBACK) ||
                   (idx_q == 9'h001 && sh_q == 8'h00) ||
                   (idx_q > 9'h001 && idx_q == {1'b0, len_q} + 9'h001);

  assign cmd_ready = (state_q == S_IDLE);
  assign tx_ready  = need_tx;
  assign busy      = (state_q != S_IDLE);

  // control byte for an operation, code in the top two bits
  function [7:0] ctrl_byte;
    input [1:0] op;
    begin
      ctrl_byte = {op, 6'h00};
    end
  endfunction

  // sequencer: select, shift, decide next byte, gap, wake pulse
  always @(posedge ref_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      state_q       <= S_IDLE;
      op_q          <= 2'h0;
      cnt_q         <= 16'h0000;
      bit_q         <= 3'h0;
      sh_q          <= 8'h00;
      samp_q        <= 1'b0;
      first_q       <= 1'b0;
      last_sent_q   <= 1'b0;
      idx_q         <= 9'h000;
      len_q         <= 8'h00;
      rx_valid      <= 1'b0;
      rx_data       <= 8'h00;
      rx_last       <= 1'b0;
      poll_flags    <= 8'h00;
      done          <= 1'b0;
      link_select_0 <= `CHCP_LINK_SEL0;
      link_select_1 <= `CHCP_LINK_SEL1;
      spi_sck       <= 1'b0;
      spi_ss_n      <= 1'b1;
      spi_mosi      <= 1'b0;
      irq_in_n      <= 1'b1;
    end else begin
      rx_valid <= 1'b0;
      rx_last  <= 1'b0;
      done     <= 1'b0;
      case (state_q)
        S_IDLE: begin
          cnt_q <= 16'h0000;
          if (cmd_wake) begin
            state_q  <= S_WAKE;
            irq_in_n <= 1'b0;
          end else if (cmd_valid) begin
            op_q        <= cmd_op;
            first_q     <= 1'b1;
            last_sent_q <= 1'b0;
            idx_q       <= 9'h000;
            sh_q        <= ctrl_byte(cmd_op);
            spi_mosi    <= cmd_op[1];
            bit_q       <= 3'h0;
            spi_ss_n    <= 1'b0;
            state_q     <= S_BIT;
          end
        end
        S_WAKE: begin
          // hold the wake line low long enough, then release
          if (cnt_q == WAKE_CYC[15:0] - 16'h0001) begin
            irq_in_n <= 1'b1;
            done     <= 1'b1;
            state_q  <= S_IDLE;
          end else begin
            cnt_q <= cnt_q + 16'h0001;
          end
        end
        S_BIT: begin
          if (cnt_q == HALF_CYC[15:0] - 16'h0001) begin
            cnt_q <= 16'h0000;
            if (!spi_sck) begin
              spi_sck <= 1'b1;
              samp_q  <= miso_sync_q[1];
            end else begin
              spi_sck <= 1'b0;
              sh_q    <= {sh_q[6:0], samp_q};
              if (bit_q == 3'h7) begin
                state_q <= S_NEXT;
              end else begin
                bit_q    <= bit_q + 3'h1;
                spi_mosi <= sh_q[6];
              end
            end
          end else begin
            cnt_q <= cnt_q + 16'h0001;
          end
        end
        S_NEXT: begin
          first_q <= 1'b0;
          bit_q   <= 3'h0;
          case (op_q)
            `CHCP_OP_SEND: begin
              if (first_q || !last_sent_q) begin
                if (tx_valid) begin
                  sh_q        <= tx_data;
                  spi_mosi    <= tx_data[7];
                  last_sent_q <= tx_last;
                  state_q     <= S_BIT;
                end
              end else begin
                spi_ss_n <= 1'b1;
                state_q  <= S_GAP;
              end
            end
            `CHCP_OP_POLL: begin
              // flags repeat until the ready bit shows, or in irq mode until the irq line goes low
              if (!first_q && (sh_q[`CHCP_FLAG_READ_BIT] || irq_ready)) begin
                poll_flags <= sh_q;
                spi_ss_n   <= 1'b1;
                state_q    <= S_GAP;
              end else begin
                sh_q     <= `CHCP_DUMMY_BYTE;
                spi_mosi <= 1'b0;
                state_q  <= S_BIT;
              end
            end
            `CHCP_OP_READ: begin
              if (first_q) begin
                sh_q     <= `CHCP_DUMMY_BYTE;
                spi_mosi <= 1'b0;
                state_q  <= S_BIT;
              end else begin
                rx_valid <= 1'b1;
                rx_data  <= sh_q;
                idx_q    <= idx_q + 9'h001;
                if (idx_q == 9'h001) begin
                  len_q <= sh_q;
                end
                if (read_end) begin
                  rx_last  <= 1'b1;
                  spi_ss_n <= 1'b1;
                  state_q  <= S_GAP;
                end else begin
                  sh_q     <= `CHCP_DUMMY_BYTE;
                  spi_mosi <= 1'b0;
                  state_q  <= S_BIT;
                end
              end
            end
            default: begin
              spi_ss_n <= 1'b1;
              state_q  <= S_GAP;
            end
          endcase
        end
        S_GAP: begin
          // select stays high between transactions
          if (cnt_q == GAP_CYC[15:0] - 16'h0001) begin
            cnt_q <= 16'h0000;
            if (op_q == `CHCP_OP_RESET) begin
              irq_in_n <= 1'b0;
              state_q  <= S_WAKE;
            end else begin
              done    <= 1'b1;
              state_q <= S_IDLE;
            end
          end else begin
            cnt_q <= cnt_q + 16'h0001;
          end
        end
        default: begin
          state_q  <= S_IDLE;
          spi_ss_n <= 1'b1;
        end
      endcase
    end
  end

endmodule // chcp_host
